// file: src/sample_clock_delay_detect_ctrl.sv
`timescale 1ns/10ps
`include "clkdly_consts.svh"

module sample_clock_delay_detect_ctrl
  import clkdly_pkg::*;
#(
  parameter int ADR_W = 12
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Clock detector pin
  input  wire logic         input_clock_detected,
  // Delay line controls
  output logic      [2:0]   delay_mode,
  output logic      [7:0]   local_superfine_steps,
  output logic      [7:0]   local_fine_steps,
  output logic      [7:0]   digital_superfine_steps,
  output logic      [7:0]   digital_fine_steps,
  // Detector and stabilizer controls
  output logic      [1:0]   detect_threshold,
  output logic              duty_stabilizer_one_en
);

  if (ADR_W < 12) begin : g_bad_adr
    $error("address bus too narrow for register map");
  end

  top_state_t st_q;
  top_state_t st_d;
  logic       det_sync;
  logic       req;
  logic       wr_take;
  logic [9:0] idx;
  logic [7:0] rd_mux;
  logic       adr_hi_ok;

  // Detector pin through two flops
  level_sync u_det_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (input_clock_detected),
    .sync_out (det_sync)
  );

  delay_channel u_local_chan (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .mode        (st_q.mode),
    .sfine_cfg   (st_q.local_sfine),
    .fine_cfg    (st_q.local_fine),
    .sfine_steps (local_superfine_steps),
    .fine_steps  (local_fine_steps)
  );

  delay_channel u_digital_chan (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .mode        (st_q.mode),
    .sfine_cfg   (st_q.dig_sfine),
    .fine_cfg    (st_q.dig_fine),
    .sfine_steps (digital_superfine_steps),
    .fine_steps  (digital_fine_steps)
  );

  always_comb begin
    idx       = wb_adr_i[11:2];
    adr_hi_ok = (wb_adr_i[1:0] == 2'h0);
    rd_mux    = 8'h00;
    if (adr_hi_ok) begin
      case (idx)
        `IDX_DELAY_MODE:   rd_mux = {5'h00, st_q.mode};
        `IDX_LOCAL_SFINE:  rd_mux = st_q.local_sfine;
        `IDX_LOCAL_FINE:   rd_mux = st_q.local_fine;
        `IDX_DIG_SFINE:    rd_mux = st_q.dig_sfine;
        `IDX_DIG_FINE:     rd_mux = st_q.dig_fine;
        `IDX_DETECT_CTRL:  rd_mux = {st_q.det_high, st_q.threshold, st_q.det_low};
        `IDX_CLOCK_STATUS: rd_mux = {7'h00, st_q.detected};
        `IDX_DCS_ONE_CTRL: rd_mux = {st_q.dcs_rsvd, st_q.dcs_en, 1'b0};
        default:           rd_mux = 8'h00;
      endcase
    end
  end

  always_comb begin
    req     = wb_cyc_i && wb_stb_i;
    wr_take = req && st_q.ack && wb_we_i && wb_sel_i[0] && adr_hi_ok;
    st_d    = st_q;
    st_d.ack      = req && !st_q.ack;
    st_d.detected = det_sync;
    if (st_q.warm != 2'h3) begin
      st_d.warm = st_q.warm + 2'h1;
    end
    if (req && !st_q.ack) begin
      st_d.rdata = rd_mux;
    end
    // Writes land on the edge where the master sees ack
    if (wr_take) begin
      case (idx)
        `IDX_DELAY_MODE:   st_d.mode        = wb_dat_i[2:0];
        `IDX_LOCAL_SFINE:  st_d.local_sfine = wb_dat_i[7:0];
        `IDX_LOCAL_FINE:   st_d.local_fine  = wb_dat_i[7:0];
        `IDX_DIG_SFINE:    st_d.dig_sfine   = wb_dat_i[7:0];
        `IDX_DIG_FINE:     st_d.dig_fine    = wb_dat_i[7:0];
        `IDX_DETECT_CTRL: begin
          st_d.det_high  = wb_dat_i[7:5];
          st_d.threshold = wb_dat_i[`THRESH_LSB+1:`THRESH_LSB];
          st_d.det_low   = wb_dat_i[2:0];
        end
        `IDX_DCS_ONE_CTRL: begin
          st_d.dcs_rsvd = wb_dat_i[7:2];
          st_d.dcs_en   = wb_dat_i[`DCS_EN_BIT];
        end
        default: begin
          st_d.ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q.ack         <= 1'b0;
      st_q.rdata       <= 8'h00;
      st_q.mode        <= `RST_DELAY_MODE;
      st_q.local_sfine <= `RST_SFINE;
      st_q.local_fine  <= `RST_FINE;
      st_q.dig_sfine   <= `RST_SFINE;
      st_q.dig_fine    <= `RST_FINE;
      st_q.det_high    <= `RST_DET_HIGH;
      st_q.threshold   <= `RST_THRESHOLD;
      st_q.det_low     <= `RST_DET_LOW;
      st_q.dcs_rsvd    <= `RST_DCS_RSVD;
      st_q.dcs_en      <= `RST_DCS_EN;
      st_q.detected    <= `RST_STATUS;
      st_q.warm        <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o               = st_q.ack;
  assign wb_dat_o               = {24'h000000, st_q.rdata};
  assign delay_mode             = st_q.mode;
  assign detect_threshold       = st_q.threshold;
  assign duty_stabilizer_one_en = st_q.dcs_en;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ack_once_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  reset_values_a: assert property (disable iff (1'b0)
    rst |=> local_fine_steps == 8'h00 && st_q.local_fine == 8'hc0 &&
      st_q.dig_fine == 8'hc0 && st_q.local_sfine == 8'h00 && st_q.mode == 3'h0)
    else $error("delay registers wrong after reset");
  dcs_reset_a: assert property (disable iff (1'b0)
    rst |=> duty_stabilizer_one_en && detect_threshold == 2'h1 && !st_q.detected)
    else $error("stabilizer or detect control wrong after reset");
  dcs_write_a: assert property (
    wr_take && wb_adr_i == 12'h470 |=> duty_stabilizer_one_en == $past(wb_dat_i[1]))
    else $error("stabilizer enable not written");
  detect_follow_a: assert property (
    st_q.warm == 2'h3 |-> st_q.detected == $past(input_clock_detected, 3))
    else $error("status does not follow detector pin");
  status_ro_a: assert property (
    wr_take && wb_adr_i == 12'h46c |=> st_q.detected == $past(det_sync))
    else $error("status bit changed by write");
  digital_fine_a: assert property (
    wr_take && wb_adr_i == 12'h450 ##1 st_q.mode == 3'h4 && st_q.dig_fine <= 8'hc0
      |=> digital_fine_steps == $past(st_q.dig_fine))
    else $error("digital fine delay not applied in mode 4");
  digital_sfine_a: assert property (
    st_q.mode == 3'h6 && st_q.dig_sfine <= 8'h80 |=> digital_superfine_steps == $past(st_q.dig_sfine))
    else $error("digital super-fine not applied in mode 6");
  read_status_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == 12'h46c
      |=> wb_dat_o == {31'h0, $past(st_q.detected)})
    else $error("status read returned wrong value");

  write_cov: cover property (wr_take && wb_adr_i == 12'h440);
  detect_rise_cov: cover property (!st_q.detected ##1 st_q.detected);
  bypass_cov: cover property ($fell(duty_stabilizer_one_en));

endmodule

// file: src/clkdly_consts.svh
`ifndef CLKDLY_CONSTS_SVH
`define CLKDLY_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_DELAY_MODE     10'h110
`define IDX_LOCAL_SFINE    10'h111
`define IDX_LOCAL_FINE     10'h112
`define IDX_DIG_SFINE      10'h113
`define IDX_DIG_FINE       10'h114
`define IDX_DETECT_CTRL    10'h11a
`define IDX_CLOCK_STATUS   10'h11b
`define IDX_DCS_ONE_CTRL   10'h11c

// Reset values
`define RST_DELAY_MODE     3'h0
`define RST_SFINE          8'h00
`define RST_FINE           8'hc0
`define RST_DET_HIGH       3'h0
`define RST_THRESHOLD      2'h1
`define RST_DET_LOW        3'h6
`define RST_DCS_RSVD       6'h00
`define RST_DCS_EN         1'b1
`define RST_STATUS         1'b0

// Delay mode codes
`define MODE_NONE          3'h0
`define MODE_FINE_LIMITED  3'h2
`define MODE_FINE_ALT      3'h3
`define MODE_FINE_FULL     3'h4
`define MODE_FINE_SUPER    3'h6

// Step limits
`define FINE_STEPS_MAX     8'hc0
`define FINE_STEPS_LIMITED 8'h10
`define SFINE_STEPS_MAX    8'h80

// Field positions
`define THRESH_LSB         3
`define DCS_EN_BIT         1

// Cycles from pin to status register
`define DETECT_LATENCY     3

`endif

// file: src/clkdly_pkg.sv
package clkdly_pkg;

  typedef struct packed {
    logic       meta;
    logic       sync;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] sfine;
    logic [7:0] fine;
  } chan_state_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [2:0] mode;
    logic [7:0] local_sfine;
    logic [7:0] local_fine;
    logic [7:0] dig_sfine;
    logic [7:0] dig_fine;
    logic [2:0] det_high;
    logic [1:0] threshold;
    logic [2:0] det_low;
    logic [5:0] dcs_rsvd;
    logic       dcs_en;
    logic       detected;
    logic [1:0] warm;
  } top_state_t;

endpackage

// file: src/level_sync.sv
`timescale 1ns/10ps
`include "clkdly_consts.svh"

module level_sync
  import clkdly_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;

endmodule

// file: src/delay_channel.sv
`timescale 1ns/10ps
`include "clkdly_consts.svh"

module delay_channel
  import clkdly_pkg::*;
#(
  parameter logic [7:0] FINE_MAX    = `FINE_STEPS_MAX,
  parameter logic [7:0] FINE_LIMIT  = `FINE_STEPS_LIMITED,
  parameter logic [7:0] SFINE_MAX   = `SFINE_STEPS_MAX
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Configuration
  input  wire logic [2:0] mode,
  input  wire logic [7:0] sfine_cfg,
  input  wire logic [7:0] fine_cfg,
  // Applied step counts
  output logic      [7:0] sfine_steps,
  output logic      [7:0] fine_steps
);

  if (FINE_LIMIT > FINE_MAX) begin : g_bad_limit
    $error("fine limit above fine maximum");
  end

  chan_state_t st_q;
  chan_state_t st_d;
  logic        sfine_on;
  logic        fine_on;
  logic [7:0]  fine_cap;

  always_comb begin
    sfine_on = (mode == `MODE_FINE_LIMITED) || (mode == `MODE_FINE_SUPER);
    fine_on  = (mode == `MODE_FINE_LIMITED) || (mode == `MODE_FINE_ALT) ||
               (mode == `MODE_FINE_FULL) || (mode == `MODE_FINE_SUPER);
    fine_cap = (mode == `MODE_FINE_LIMITED) ? FINE_LIMIT : FINE_MAX;
    st_d     = st_q;
    st_d.sfine = '0;
    st_d.fine  = '0;
    if (sfine_on) begin
      st_d.sfine = (sfine_cfg > SFINE_MAX) ? SFINE_MAX : sfine_cfg;
    end
    if (fine_on) begin
      st_d.fine = (fine_cfg > fine_cap) ? fine_cap : fine_cfg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfine_steps = st_q.sfine;
  assign fine_steps  = st_q.fine;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sfine_gated_a: assert property (
    !(mode == 3'h2 || mode == 3'h6) |=> sfine_steps == 8'h00)
    else $error("super-fine applied outside modes 2 and 6");
  fine_gated_a: assert property (
    (mode == 3'h0 || mode == 3'h1 || mode == 3'h5 || mode == 3'h7) |=> fine_steps == 8'h00)
    else $error("fine applied outside modes 2 3 4 6");
  limited_fine_a: assert property (
    mode == 3'h2 |=> fine_steps <= 8'h10 && (fine_steps == $past(fine_cfg) || fine_steps == 8'h10))
    else $error("limited fine mode exceeded step 16");
  full_range_a: assert property (
    mode == 3'h6 && fine_cfg <= 8'hc0 && sfine_cfg <= 8'h80
      |=> fine_steps == $past(fine_cfg) && sfine_steps == $past(sfine_cfg))
    else $error("mode 6 did not pass both delays");
  full_mode_cov: cover property (mode == 3'h6 ##1 fine_steps == 8'hc0);

endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`include "clkdly_consts.svh"

module tb_top
  import clkdly_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        input_clock_detected;
  logic [2:0]  delay_mode;
  logic [7:0]  local_superfine_steps;
  logic [7:0]  local_fine_steps;
  logic [7:0]  digital_superfine_steps;
  logic [7:0]  digital_fine_steps;
  logic [1:0]  detect_threshold;
  logic        duty_stabilizer_one_en;
  logic [31:0] rd;
  int          failures;
  int          checks;

  sample_clock_delay_detect_ctrl #(.ADR_W(12)) dut (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .input_clock_detected    (input_clock_detected),
    .delay_mode              (delay_mode),
    .local_superfine_steps   (local_superfine_steps),
    .local_fine_steps        (local_fine_steps),
    .digital_superfine_steps (digital_superfine_steps),
    .digital_fine_steps      (digital_fine_steps),
    .detect_threshold        (detect_threshold),
    .duty_stabilizer_one_en  (duty_stabilizer_one_en)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] a(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [7:0] exp_sf(input logic [2:0] m, input logic [7:0] v);
    if (m == `MODE_FINE_LIMITED || m == `MODE_FINE_SUPER)
      return (v > `SFINE_STEPS_MAX) ? `SFINE_STEPS_MAX : v;
    return 8'h00;
  endfunction

  function automatic logic [7:0] exp_fn(input logic [2:0] m, input logic [7:0] v);
    logic [7:0] lim;
    lim = (m == `MODE_FINE_LIMITED) ? `FINE_STEPS_LIMITED : `FINE_STEPS_MAX;
    if (m inside {3'h2, 3'h3, 3'h4, 3'h6})
      return (v > lim) ? lim : v;
    return 8'h00;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [11:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("[FAIL] ack expected 1 seen %b", wb_ack_o);
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] adr, input logic [7:0] d);
    logic [31:0] unused;
    xfer(1'b1, adr, 4'h1, {24'h0, d}, unused);
  endtask

  task automatic rdchk(input string name, input logic [11:0] adr, input logic [7:0] e);
    logic [31:0] v;
    xfer(1'b0, adr, 4'h1, 32'h0, v);
    check(name, v, {24'h0, e});
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    results();
  end

  initial begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    input_clock_detected = 1'b0;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values and outputs
    rdchk("mode_rst", a(`IDX_DELAY_MODE), 8'h00);
    rdchk("lsf_rst", a(`IDX_LOCAL_SFINE), 8'h00);
    rdchk("lfn_rst", a(`IDX_LOCAL_FINE), 8'hc0);
    rdchk("dsf_rst", a(`IDX_DIG_SFINE), 8'h00);
    rdchk("dfn_rst", a(`IDX_DIG_FINE), 8'hc0);
    rdchk("det_rst", a(`IDX_DETECT_CTRL), 8'h0e);
    rdchk("stat_rst", a(`IDX_CLOCK_STATUS), 8'h00);
    rdchk("dcs_rst", a(`IDX_DCS_ONE_CTRL), 8'h02);
    check("thr_out", {30'h0, detect_threshold}, 32'h1);
    check("dcs_out", {31'h0, duty_stabilizer_one_en}, 32'h1);
    check("lfn_out0", {24'h0, local_fine_steps}, 32'h0);
    // Every mode code; digital values beyond the limits, local fine beyond step 16
    wr(a(`IDX_LOCAL_SFINE), 8'h08);
    wr(a(`IDX_DIG_SFINE), 8'h90);
    wr(a(`IDX_LOCAL_FINE), 8'h14);
    wr(a(`IDX_DIG_FINE), 8'hc8);
    rdchk("dsf_store", a(`IDX_DIG_SFINE), 8'h90);
    for (int m = 0; m < 8; m++) begin
      wr(a(`IDX_DELAY_MODE), 8'(m));
      repeat (2) @(posedge clk_sys);
      check("mode", {29'h0, delay_mode}, 32'(m));
      check("lsf", {24'h0, local_superfine_steps}, {24'h0, exp_sf(3'(m), 8'h08)});
      check("dsf", {24'h0, digital_superfine_steps}, {24'h0, exp_sf(3'(m), 8'h90)});
      check("lfn", {24'h0, local_fine_steps}, {24'h0, exp_fn(3'(m), 8'h14)});
      check("dfn", {24'h0, digital_fine_steps}, {24'h0, exp_fn(3'(m), 8'hc8)});
    end
    // In-range digital fine reaches the steps in modes 4 and 6, super-fine only in 6
    wr(a(`IDX_DELAY_MODE), 8'h04);
    wr(a(`IDX_DIG_FINE), 8'h50);
    wr(a(`IDX_DIG_SFINE), 8'h80);
    repeat (2) @(posedge clk_sys);
    check("dfn_m4", {24'h0, digital_fine_steps}, 32'h50);
    check("dsf_m4", {24'h0, digital_superfine_steps}, 32'h0);
    wr(a(`IDX_DELAY_MODE), 8'h06);
    repeat (2) @(posedge clk_sys);
    check("dsf_m6", {24'h0, digital_superfine_steps}, 32'h80);
    check("dfn_m6", {24'h0, digital_fine_steps}, 32'h50);
    // Threshold field
    wr(a(`IDX_DETECT_CTRL), 8'h18);
    rdchk("det_11", a(`IDX_DETECT_CTRL), 8'h18);
    check("thr_11", {30'h0, detect_threshold}, 32'h3);
    // Status follows the detector and ignores writes
    input_clock_detected <= 1'b1;
    repeat (`DETECT_LATENCY + 1) @(posedge clk_sys);
    rdchk("stat_1", a(`IDX_CLOCK_STATUS), 8'h01);
    wr(a(`IDX_CLOCK_STATUS), 8'h00);
    rdchk("stat_ro", a(`IDX_CLOCK_STATUS), 8'h01);
    input_clock_detected <= 1'b0;
    repeat (`DETECT_LATENCY + 1) @(posedge clk_sys);
    rdchk("stat_0", a(`IDX_CLOCK_STATUS), 8'h00);
    // Stabilizer bypass and enable
    wr(a(`IDX_DCS_ONE_CTRL), 8'h00);
    rdchk("dcs_0", a(`IDX_DCS_ONE_CTRL), 8'h00);
    check("dcs_byp", {31'h0, duty_stabilizer_one_en}, 32'h0);
    wr(a(`IDX_DCS_ONE_CTRL), 8'hff);
    rdchk("dcs_1", a(`IDX_DCS_ONE_CTRL), 8'hfe);
    check("dcs_en", {31'h0, duty_stabilizer_one_en}, 32'h1);
    // Refused accesses: unmapped, misaligned, lane 0 not selected
    rdchk("unmapped", 12'h474, 8'h00);
    wr(a(`IDX_LOCAL_SFINE) | 12'h001, 8'h55);
    xfer(1'b1, a(`IDX_LOCAL_SFINE), 4'he, 32'h66, rd);
    rdchk("lsf_keep", a(`IDX_LOCAL_SFINE), 8'h08);
    results();
  end
endmodule
